// >>> core/lpm_pkg.sv
// Constants, types and address map for the low-power mode controller
// What this block does
// - Two-byte vectors; converter-done vector at FFDE
// - Async serial vectors FFE2, FFE4, FFE6
// - Sync serial vectors FFE8 and FFEA
// - Timer two FFEC, FFF0; FFEE reserved
// - Timer one vectors FFF2, FFF4, FFF6
// - Wait stops core clock, bus runs
// - Stop halts core; bus unless oscillator kept
// - Converter runs in wait, may wake
// - Stop aborts conversion; resumes after interrupt wake
// - Break ends stop, sets break-during-wait flag
// - Wait clears mask; reset wake sets it
// - Stop clears mask; reset wake sets it
// - Core clock restarts after oscillator settles
// - Stop without oscillator kills clock generator outputs
// - Stop clears base clock select until software rewrites it
// - Oscillator kept: PLL off, crystal runs
// - Stop gates watchdog clock, clears prescaler
// - Stop ignored unless stop enable set
// - Reset wakes load reset vector FFFE
// - External pin falling edge wakes, vector FFFA
package lpm_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int OSC_STAB_TIME_NS = 81920;
    localparam int OSC_STAB_CYCLES = (OSC_STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STAB_CNT_W = 13;

    // ------------------------------------------------------------
    // Wake sources and vectors
    // ------------------------------------------------------------
    localparam int NUM_SRC = 16;
    localparam int SRC_TIMEBASE = 0;
    localparam int SRC_ADC = 1;
    localparam int SRC_KEYBOARD = 2;
    localparam int SRC_IRQ_PIN = 14;
    localparam int SRC_BREAK = 15;
    localparam logic [15:0] VEC_RESET = 16'hfffe;
    localparam logic [15:0] VEC_RESERVED = 16'hffee;
    // Index 0 timebase .. 15 break, one 16-bit address each
    // All sixteen source vectors
    localparam logic [NUM_SRC*16-1:0] VEC_TABLE = {
        16'hfffc, 16'hfffa, 16'hfff8, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0, 16'hffec,
        16'hffea, 16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0, 16'hffde, 16'hffdc};
    localparam logic [NUM_SRC-1:0] WAKE_IN_WAIT = 16'hffff;
    localparam logic [NUM_SRC-1:0] WAKE_IN_STOP = 16'hc004;
    localparam logic [NUM_SRC-1:0] WAKE_STOP_OSC = 16'h0001;

    // ------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_PLL_CTRL = 8'h04;
    localparam logic [7:0] OFS_ADC_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_WAKE_PEND = 8'h10;
    localparam int BIT_STOP_ENABLE = 0;
    localparam int BIT_OSC_RUN_IN_STOP = 1;
    localparam int BIT_BASE_CLOCK_SELECT = 0;
    localparam int BIT_PLL_POWER_ON = 1;
    localparam int BIT_BW_FLAG = 4;
    localparam int VEC_LSB = 16;
    localparam logic [1:0] CONFIG_RESET = 2'h0;
    localparam logic [1:0] PLL_CTRL_RESET = 2'h2;
    localparam logic [4:0] ADC_CH_RESET = 5'h1f;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_WAIT = 4'h2,
        ST_STOP = 4'h4,
        ST_RECOVER = 4'h8
    } lpm_state_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic bus_clk_en;
        logic osc_en;
        logic pll_en;
        logic crystal_clock_en;
        logic clock_gen_interrupt_en;
        logic watchdog_clk_en;
    } clk_ctrl_t;

endpackage

// >>> core/low_power_mode_control.sv
// Low-power mode controller with wake vectoring and register slave
`timescale 1ns/10ps
`default_nettype none
module low_power_mode_control
    import lpm_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    input wire logic [7:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [31:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [31:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    input wire logic I_WAIT_EXEC,
    input wire logic I_STOP_EXEC,
    input wire logic [15:0] I_INT_REQ,
    input wire logic I_IRQ_PIN_N,
    input wire logic I_RST_PIN_N,
    input wire logic I_WATCHDOG_TIMEOUT,
    input wire logic I_VOLTAGE_MONITOR_RESET,
    output clk_ctrl_t O_CLK_CTRL,
    output logic O_IMASK_CLR,
    output logic O_IMASK_SET,
    output logic O_CPU_RESET,
    output logic O_VECTOR_VALID,
    output logic [15:0] O_VECTOR_ADDR,
    output logic O_ADC_ABORT,
    output logic O_ADC_HOLD,
    output logic [4:0] O_ADC_CHANNEL_SELECT,
    output logic O_WATCHDOG_PRESCALE_CLR,
    output logic O_BREAK_UNIT_EN,
    output logic O_BREAK_DURING_WAIT_FLAG,
    output logic O_BASE_CLOCK_SELECT,
    output logic O_PLL_POWER_ON,
    output logic [3:0] O_MODE
);

    // ------------------------------------------------------------
    // Reset and pin synchronisers
    // ------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;
    logic irq_meta_reg;
    logic irq_sync_reg;
    logic irq_prev_reg;
    logic rpin_meta_reg;
    logic rpin_sync_reg;

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            irq_meta_reg <= 1'b1;
            irq_sync_reg <= 1'b1;
            irq_prev_reg <= 1'b1;
            rpin_meta_reg <= 1'b1;
            rpin_sync_reg <= 1'b1;
        end
        else
        begin
            irq_meta_reg <= I_IRQ_PIN_N;
            irq_sync_reg <= irq_meta_reg;
            irq_prev_reg <= irq_sync_reg;
            rpin_meta_reg <= I_RST_PIN_N;
            rpin_sync_reg <= rpin_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    lpm_state_t state_reg;
    lpm_state_t state_next;
    logic stop_enable_reg;
    logic osc_run_in_stop_reg;
    logic base_clock_select_reg;
    logic pll_power_on_reg;
    logic [4:0] adc_channel_select_reg;
    logic break_during_wait_flag_reg;
    logic irq_pend_reg;
    logic [STAB_CNT_W-1:0] stab_cnt_reg;
    logic [15:0] wake_vec_reg;
    logic wake_is_reset_reg;
    logic [NUM_SRC-1:0] src;
    logic [NUM_SRC-1:0] wake_ok;
    logic any_wake;
    logic [15:0] enc_vec;
    logic enc_break;
    logic rst_wake;
    logic irq_fall;
    logic stab_done;
    logic go_wait;
    logic go_stop;
    logic wake_now;
    logic acc;
    logic wr_en;
    logic [31:0] rd_val;
    logic bw_clr;

    assign irq_fall = irq_prev_reg & ~irq_sync_reg;
    assign rst_wake = ~rpin_sync_reg | I_WATCHDOG_TIMEOUT | I_VOLTAGE_MONITOR_RESET;
    assign stab_done = (stab_cnt_reg == STAB_CNT_W'(OSC_STAB_CYCLES - 1));
    assign go_wait = (state_reg == ST_RUN) && I_WAIT_EXEC;
    assign go_stop = (state_reg == ST_RUN) && !I_WAIT_EXEC && I_STOP_EXEC && stop_enable_reg;

    // ------------------------------------------------------------
    // Wake qualification and priority
    // ------------------------------------------------------------
    always_comb
    begin
        src = I_INT_REQ;
        src[SRC_IRQ_PIN] = I_INT_REQ[SRC_IRQ_PIN] | irq_pend_reg;
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi = gi + 1)
        begin : g_qual
            assign wake_ok[gi] = src[gi] & (((state_reg == ST_WAIT) & WAKE_IN_WAIT[gi])
                | ((state_reg == ST_STOP) & (WAKE_IN_STOP[gi] | (osc_run_in_stop_reg & WAKE_STOP_OSC[gi]))));
        end
    endgenerate

    assign any_wake = |wake_ok;

    always_comb
    begin
        enc_vec = VEC_TABLE[SRC_TIMEBASE*16 +: 16];
        enc_break = 1'b0;
        for (int i = 0; i < NUM_SRC; i++)
        begin
            if (wake_ok[i])
            begin
                enc_vec = VEC_TABLE[i*16 +: 16];
                enc_break = (i == SRC_BREAK);
            end
        end
    end

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    // Three modes plus settle
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN:
            begin
                if (go_wait)
                    state_next = ST_WAIT;
                else if (go_stop)
                    state_next = ST_STOP;
            end
            ST_WAIT:
            begin
                if (rst_wake || any_wake)
                    state_next = ST_RUN;
            end
            ST_STOP:
            begin
                if (rst_wake || any_wake)
                    state_next = ST_RECOVER;
            end
            ST_RECOVER:
            begin
                if (stab_done)
                    state_next = ST_RUN;
            end
            default:
                state_next = ST_RUN;
        endcase
    end

    assign wake_now = ((state_reg == ST_WAIT) && (rst_wake || any_wake)) || ((state_reg == ST_RECOVER) && stab_done);

    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= ST_RUN;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
            stab_cnt_reg <= '0;
        else if (state_reg == ST_RECOVER)
            stab_cnt_reg <= stab_cnt_reg + STAB_CNT_W'(1);
        else
            stab_cnt_reg <= '0;
    end

    // Latched external edge until the wake is served
    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
            irq_pend_reg <= 1'b0;
        else if (irq_fall && state_reg != ST_RUN)
            irq_pend_reg <= 1'b1;
        else if (wake_now || state_reg == ST_RUN)
            irq_pend_reg <= 1'b0;
    end

    // Stop wake captured in stop, held while the oscillator settles
    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_vec_reg <= VEC_RESET;
            wake_is_reset_reg <= 1'b0;
        end
        else if (state_reg == ST_STOP)
        begin
            wake_is_reset_reg <= rst_wake;
            wake_vec_reg <= rst_wake ? VEC_RESET : enc_vec;
        end
    end

    // ------------------------------------------------------------
    // Core-facing pulses and vector
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            O_IMASK_CLR <= 1'b0;
            O_IMASK_SET <= 1'b0;
            O_CPU_RESET <= 1'b0;
            O_VECTOR_VALID <= 1'b0;
            O_VECTOR_ADDR <= VEC_RESET;
            O_ADC_ABORT <= 1'b0;
            O_WATCHDOG_PRESCALE_CLR <= 1'b0;
        end
        else
        begin
            O_IMASK_CLR <= go_wait || go_stop;
            O_ADC_ABORT <= go_stop;
            O_WATCHDOG_PRESCALE_CLR <= go_stop;
            O_VECTOR_VALID <= wake_now;
            if (state_reg == ST_WAIT && wake_now)
            begin
                O_IMASK_SET <= rst_wake;
                O_CPU_RESET <= rst_wake;
                O_VECTOR_ADDR <= rst_wake ? VEC_RESET : enc_vec;
            end
            else if (state_reg == ST_RECOVER && wake_now)
            begin
                O_IMASK_SET <= wake_is_reset_reg;
                O_CPU_RESET <= wake_is_reset_reg;
                O_VECTOR_ADDR <= wake_vec_reg;
            end
            else
            begin
                O_IMASK_SET <= 1'b0;
                O_CPU_RESET <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Clock enables per mode
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            O_CLK_CTRL <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            O_ADC_HOLD <= 1'b0;
            O_BREAK_UNIT_EN <= 1'b1;
            O_MODE <= ST_RUN;
        end
        else
        begin
            O_MODE <= state_next;
            // Core off, bus on in wait
            O_CLK_CTRL.cpu_clk_en <= (state_next == ST_RUN);
            // Bus off in stop unless oscillator kept
            O_CLK_CTRL.bus_clk_en <= (state_next == ST_RUN) || (state_next == ST_WAIT)
                || ((state_next == ST_STOP) && osc_run_in_stop_reg);
            O_CLK_CTRL.osc_en <= !((state_next == ST_STOP) && !osc_run_in_stop_reg);
            O_CLK_CTRL.crystal_clock_en <= !((state_next == ST_STOP) && !osc_run_in_stop_reg)
                && (state_next != ST_RECOVER);
            O_CLK_CTRL.pll_en <= pll_power_on_reg && (state_next != ST_STOP) && (state_next != ST_RECOVER);
            O_CLK_CTRL.clock_gen_interrupt_en <= (state_next != ST_STOP) && (state_next != ST_RECOVER);
            O_CLK_CTRL.watchdog_clk_en <= (state_next != ST_STOP) && (state_next != ST_RECOVER);
            O_ADC_HOLD <= (state_next == ST_STOP) || (state_next == ST_RECOVER);
            O_BREAK_UNIT_EN <= (state_next != ST_STOP);
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave, one wait cycle per access
    // ------------------------------------------------------------
    assign acc = (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST;
    assign wr_en = I_AVS_WRITE && !O_AVS_WAITREQUEST;
    assign bw_clr = wr_en && (I_AVS_ADDRESS == OFS_STATUS) && I_AVS_BYTEENABLE[0]
        && I_AVS_WRITEDATA[BIT_BW_FLAG];

    always_comb
    begin
        rd_val = 32'h0000_0000;
        if (I_AVS_ADDRESS == OFS_CONFIG)
        begin
            rd_val[BIT_STOP_ENABLE] = stop_enable_reg;
            rd_val[BIT_OSC_RUN_IN_STOP] = osc_run_in_stop_reg;
        end
        else if (I_AVS_ADDRESS == OFS_PLL_CTRL)
        begin
            rd_val[BIT_BASE_CLOCK_SELECT] = base_clock_select_reg;
            rd_val[BIT_PLL_POWER_ON] = pll_power_on_reg;
        end
        else if (I_AVS_ADDRESS == OFS_ADC_CTRL)
            rd_val[4:0] = adc_channel_select_reg;
        else if (I_AVS_ADDRESS == OFS_STATUS)
        begin
            rd_val[3:0] = state_reg;
            rd_val[BIT_BW_FLAG] = break_during_wait_flag_reg;
            rd_val[VEC_LSB +: 16] = O_VECTOR_ADDR;
        end
        else if (I_AVS_ADDRESS == OFS_WAKE_PEND)
            rd_val[NUM_SRC-1:0] = src;
    end

    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA <= 32'h0000_0000;
        end
        else
        begin
            O_AVS_WAITREQUEST <= !acc;
            if (acc && I_AVS_READ)
                O_AVS_READDATA <= rd_val;
        end
    end

    // Configuration bits
    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stop_enable_reg <= CONFIG_RESET[BIT_STOP_ENABLE];
            osc_run_in_stop_reg <= CONFIG_RESET[BIT_OSC_RUN_IN_STOP];
            adc_channel_select_reg <= ADC_CH_RESET;
        end
        else if (wr_en && I_AVS_BYTEENABLE[0])
        begin
            if (I_AVS_ADDRESS == OFS_CONFIG)
            begin
                stop_enable_reg <= I_AVS_WRITEDATA[BIT_STOP_ENABLE];
                osc_run_in_stop_reg <= I_AVS_WRITEDATA[BIT_OSC_RUN_IN_STOP];
            end
            else if (I_AVS_ADDRESS == OFS_ADC_CTRL)
                adc_channel_select_reg <= I_AVS_WRITEDATA[4:0];
        end
    end

    // PLL control; stop entry forces crystal source
    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            base_clock_select_reg <= PLL_CTRL_RESET[BIT_BASE_CLOCK_SELECT];
            pll_power_on_reg <= PLL_CTRL_RESET[BIT_PLL_POWER_ON];
        end
        else
        begin
            if (wr_en && I_AVS_BYTEENABLE[0] && I_AVS_ADDRESS == OFS_PLL_CTRL)
            begin
                base_clock_select_reg <= I_AVS_WRITEDATA[BIT_BASE_CLOCK_SELECT];
                pll_power_on_reg <= I_AVS_WRITEDATA[BIT_PLL_POWER_ON];
            end
            if (go_stop)
                base_clock_select_reg <= 1'b0;
        end
    end

    // Break wake sets flag, set wins
    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
            break_during_wait_flag_reg <= 1'b0;
        else if ((state_reg == ST_WAIT || state_reg == ST_STOP) && !rst_wake && enc_break && any_wake)
            break_during_wait_flag_reg <= 1'b1;
        else if (bw_clr)
            break_during_wait_flag_reg <= 1'b0;
    end

    // ------------------------------------------------------------
    // Register copies to outputs
    // ------------------------------------------------------------
    always_ff @(posedge I_SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            O_ADC_CHANNEL_SELECT <= ADC_CH_RESET;
            O_BREAK_DURING_WAIT_FLAG <= 1'b0;
            O_BASE_CLOCK_SELECT <= PLL_CTRL_RESET[BIT_BASE_CLOCK_SELECT];
            O_PLL_POWER_ON <= PLL_CTRL_RESET[BIT_PLL_POWER_ON];
        end
        else
        begin
            O_ADC_CHANNEL_SELECT <= adc_channel_select_reg;
            O_BREAK_DURING_WAIT_FLAG <= break_during_wait_flag_reg;
            O_BASE_CLOCK_SELECT <= base_clock_select_reg;
            O_PLL_POWER_ON <= pll_power_on_reg;
        end
    end

endmodule
`default_nettype wire

// >>> test/lpm_core_model.sv
// Core and peripheral model raising instructions and wake requests
`timescale 1ns/10ps
`default_nettype none
module lpm_core_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wait_cmd,
    input wire logic i_stop_cmd,
    input wire logic [15:0] i_req_set,
    input wire logic i_vector_valid,
    output logic o_wait_exec,
    output logic o_stop_exec,
    output logic [15:0] o_int_req
);
always_ff @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        o_wait_exec <= 1'b0;
        o_stop_exec <= 1'b0;
        o_int_req <= 16'h0000;
    end
    else
    begin
        o_wait_exec <= i_wait_cmd;
        o_stop_exec <= i_stop_cmd;
        o_int_req <= i_vector_valid ? i_req_set : (o_int_req | i_req_set);
    end
end
endmodule
`default_nettype wire

// >>> test/low_power_mode_control_assertions.sv
// Assertion checker for the low-power mode controller
`timescale 1ns/10ps
`default_nettype none
module lpm_checker
    import lpm_pkg::*;
(
    input wire logic I_SYS_CLK,
    input wire logic I_RESETN,
    input wire logic I_WAIT_EXEC,
    input wire logic [15:0] I_INT_REQ,
    input wire logic I_RST_PIN_N,
    input wire logic I_WATCHDOG_TIMEOUT,
    input wire logic I_VOLTAGE_MONITOR_RESET,
    input wire clk_ctrl_t O_CLK_CTRL,
    input wire logic O_IMASK_CLR,
    input wire logic O_IMASK_SET,
    input wire logic O_CPU_RESET,
    input wire logic O_VECTOR_VALID,
    input wire logic [15:0] O_VECTOR_ADDR,
    input wire logic O_ADC_ABORT,
    input wire logic O_ADC_HOLD,
    input wire logic O_WATCHDOG_PRESCALE_CLR,
    input wire logic O_BREAK_UNIT_EN,
    input wire logic O_BASE_CLOCK_SELECT,
    input wire logic [3:0] O_MODE
);
default clocking @(posedge I_SYS_CLK); endclocking
default disable iff (!I_RESETN);
logic [12:0] rec_cnt;
// Counts cycles spent settling
always_ff @(posedge I_SYS_CLK or negedge I_RESETN)
begin
    if (!I_RESETN)
        rec_cnt <= 13'h0000;
    else if (O_MODE != 4'h8)
        rec_cnt <= 13'h0000;
    else if (rec_cnt != 13'h1fff)
        rec_cnt <= rec_cnt + 13'h0001;
end
sequence s_stop_entry;
    O_MODE == 4'h4 && $past(O_MODE) == 4'h1;
endsequence
sequence s_wait_brk;
    O_MODE == 4'h2 && I_INT_REQ[15] && !I_WATCHDOG_TIMEOUT && !I_VOLTAGE_MONITOR_RESET
        && I_RST_PIN_N && $past(I_RST_PIN_N, 2);
endsequence
property p_wait_entry;
    O_MODE == 4'h1 && I_WAIT_EXEC |=> O_MODE == 4'h2 && O_IMASK_CLR && !O_CLK_CTRL.cpu_clk_en;
endproperty
property p_wait_clk;
    O_MODE == 4'h2 |-> O_CLK_CTRL.bus_clk_en && !O_CLK_CTRL.cpu_clk_en;
endproperty
property p_stop_clk;
    O_MODE == 4'h4 |-> !O_CLK_CTRL.cpu_clk_en && !O_CLK_CTRL.pll_en && !O_BREAK_UNIT_EN && O_ADC_HOLD;
endproperty
property p_stop_entry;
    s_stop_entry |-> O_ADC_ABORT && O_WATCHDOG_PRESCALE_CLR && O_IMASK_CLR;
endproperty
property p_bcs_clear;
    s_stop_entry |=> !O_BASE_CLOCK_SELECT [*3];
endproperty
property p_recover;
    O_MODE == 4'h1 && $past(O_MODE) == 4'h8 |-> rec_cnt == 13'h1000;
endproperty
property p_wait_wake;
    s_wait_brk |=> O_VECTOR_VALID && O_VECTOR_ADDR == 16'hfffc && O_MODE == 4'h1;
endproperty
property p_reset_wake;
    O_MODE == 4'h2 && I_WATCHDOG_TIMEOUT |=> O_VECTOR_VALID && O_VECTOR_ADDR == 16'hfffe && O_IMASK_SET && O_CPU_RESET;
endproperty
property p_vec_run;
    O_VECTOR_VALID |-> O_MODE == 4'h1 && O_CLK_CTRL.cpu_clk_en && O_VECTOR_ADDR != 16'hffee;
endproperty
property p_mask_pulse;
    O_IMASK_CLR |-> $past(O_MODE) == 4'h1 && O_MODE != 4'h1;
endproperty
a_wait_entry: assert property (p_wait_entry) else $error("wait entry wrong");
a_wait_clk: assert property (p_wait_clk) else $error("wait clocks wrong");
a_stop_clk: assert property (p_stop_clk) else $error("stop clocks wrong");
a_stop_entry: assert property (p_stop_entry) else $error("stop entry pulses missing");
a_bcs_clear: assert property (p_bcs_clear) else $error("base clock select kept");
a_recover: assert property (p_recover) else $error("core restarted early");
a_wait_wake: assert property (p_wait_wake) else $error("break wake wrong");
a_reset_wake: assert property (p_reset_wake) else $error("reset wake wrong");
a_vec_run: assert property (p_vec_run) else $error("vector outside run");
a_mask_pulse: assert property (p_mask_pulse) else $error("mask clear misplaced");
endmodule
bind low_power_mode_control lpm_checker u_chk (.I_SYS_CLK, .I_RESETN, .I_WAIT_EXEC, .I_INT_REQ, .I_RST_PIN_N,
    .I_WATCHDOG_TIMEOUT, .I_VOLTAGE_MONITOR_RESET, .O_CLK_CTRL, .O_IMASK_CLR, .O_IMASK_SET, .O_CPU_RESET,
    .O_VECTOR_VALID, .O_VECTOR_ADDR, .O_ADC_ABORT, .O_ADC_HOLD, .O_WATCHDOG_PRESCALE_CLR, .O_BREAK_UNIT_EN,
    .O_BASE_CLOCK_SELECT, .O_MODE);
`default_nettype wire

// >>> test/low_power_mode_control_tb.sv
// Self-checking bench for the low-power mode controller
`timescale 1ns/10ps
`default_nettype none
module low_power_mode_control_tb import lpm_pkg::*;;
logic clk = 1'b0;
logic rst_n = 1'b0;
logic rd = 1'b0;
logic wr = 1'b0;
logic irq_n = 1'b1;
logic wdt = 1'b0;
logic rpin_n = 1'b1;
logic lvr = 1'b0;
logic wait_cmd = 1'b0;
logic stop_cmd = 1'b0;
logic [7:0] addr = 8'h00;
logic [31:0] wdata = 32'h0;
logic [15:0] req_set = 16'h0;
logic [31:0] rdata, q;
logic [15:0] int_req, vaddr;
logic [3:0] mode;
logic [4:0] chsel;
logic wreq, vv, imset, base_clock_select, brk_en, wexec, sexec, seen_set;
clk_ctrl_t cc;
int err_total = 0;
int total_checks = 0;
int cyc = 0;
int rec_n = 0;
localparam logic [15:0] VEXP [16] = '{16'hffdc, 16'hffde, 16'hffe0, 16'hffe2, 16'hffe4, 16'hffe6, 16'hffe8,
    16'hffea, 16'hffec, 16'hfff0, 16'hfff2, 16'hfff4, 16'hfff6, 16'hfff8, 16'hfffa, 16'hfffc};
always #10 clk = ~clk;
lpm_core_model u_core (.i_clk(clk), .i_rst_n(rst_n), .i_wait_cmd(wait_cmd), .i_stop_cmd(stop_cmd),
    .i_req_set(req_set), .i_vector_valid(vv), .o_wait_exec(wexec), .o_stop_exec(sexec), .o_int_req(int_req));
low_power_mode_control dut (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_AVS_ADDRESS(addr), .I_AVS_READ(rd),
    .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(4'hf), .O_AVS_READDATA(rdata),
    .O_AVS_WAITREQUEST(wreq), .I_WAIT_EXEC(wexec), .I_STOP_EXEC(sexec), .I_INT_REQ(int_req),
    .I_IRQ_PIN_N(irq_n), .I_RST_PIN_N(rpin_n), .I_WATCHDOG_TIMEOUT(wdt), .I_VOLTAGE_MONITOR_RESET(lvr),
    .O_CLK_CTRL(cc), .O_IMASK_CLR(), .O_IMASK_SET(imset), .O_CPU_RESET(), .O_VECTOR_VALID(vv),
    .O_VECTOR_ADDR(vaddr), .O_ADC_ABORT(), .O_ADC_HOLD(), .O_ADC_CHANNEL_SELECT(chsel),
    .O_WATCHDOG_PRESCALE_CLR(), .O_BREAK_UNIT_EN(brk_en), .O_BREAK_DURING_WAIT_FLAG(),
    .O_BASE_CLOCK_SELECT(base_clock_select), .O_PLL_POWER_ON(), .O_MODE(mode));
// --------
// Helpers
// --------
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
        err_total++;
        $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
endtask
task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do
        @(posedge clk);
    while (wreq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
endtask
task automatic enter(input logic st);
    wait_cmd <= !st;
    stop_cmd <= st;
    @(posedge clk);
    wait_cmd <= 1'b0;
    stop_cmd <= 1'b0;
    repeat (2) @(posedge clk);
endtask
task automatic wake(input logic [15:0] s, input logic [15:0] e);
    req_set <= s;
    @(posedge clk);
    req_set <= 16'h0;
    while (vv !== 1'b1)
    begin
        @(posedge clk);
        if (mode === 4'h8)
            rec_n++;
    end
    seen_set = imset;
    chk(vaddr, e);
endtask
task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
        $display("ALL CHECKS OK");
    else
        $display("CHECKS NOT OK");
    $finish;
endtask
// --------
// Scenarios
// --------
task automatic t_reset();
    chk(mode, 4'h1);
    bus(1'b0, OFS_CONFIG, 32'h0, q);
    chk(q[1:0], 2'h0);
    bus(1'b0, OFS_PLL_CTRL, 32'h0, q);
    chk(q[1:0], 2'h2);
    bus(1'b1, OFS_ADC_CTRL, 32'h3, q);
    @(posedge clk);
    chk(chsel, 5'h03);
    bus(1'b1, 8'h14, 32'hff, q);
    bus(1'b0, 8'h14, 32'h0, q);
    chk(q, 32'h0);
endtask
task automatic t_wait_all();
    for (int i = 0; i < 16; i++)
    begin
        enter(1'b0);
        chk({mode, cc.cpu_clk_en, cc.bus_clk_en}, 6'h09);
        wake(16'h0001 << i, VEXP[i]);
    end
    enter(1'b0);
    wake(16'h0108, 16'hffec);
endtask
task automatic t_stop_refused();
    enter(1'b1);
    chk(mode, 4'h1);
endtask
task automatic t_stop_irq();
    bus(1'b1, OFS_CONFIG, 32'h1, q);
    bus(1'b1, OFS_PLL_CTRL, 32'h3, q);
    enter(1'b1);
    chk({mode, cc}, 11'h200);
    @(posedge clk);
    chk({base_clock_select, brk_en}, 2'h0);
    rec_n = 0;
    irq_n <= 1'b0;
    wake(16'h0, 16'hfffa);
    chk(rec_n == 4096, 1'b1);
    chk({cc.cpu_clk_en, base_clock_select}, 2'h2);
    irq_n <= 1'b1;
endtask
task automatic t_stop_osc();
    bus(1'b1, OFS_CONFIG, 32'h3, q);
    bus(1'b1, OFS_STATUS, 32'h10, q);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk(q[4], 1'b0);
    enter(1'b1);
    chk({cc.osc_en, cc.pll_en, cc.crystal_clock_en}, 3'h5);
    wake(16'h8000, 16'hfffc);
    bus(1'b0, OFS_STATUS, 32'h0, q);
    chk(q[4], 1'b1);
    enter(1'b1);
    wake(16'h0001, 16'hffdc);
endtask
task automatic t_reset_wake();
    for (int k = 0; k < 3; k++)
    begin
        enter(1'b0);
        {rpin_n, lvr, wdt} <= 3'b100 ^ (3'b001 << k);
        wake(16'h0, 16'hfffe);
        chk(seen_set, 1'b1);
        {rpin_n, lvr, wdt} <= 3'b100;
    end
endtask
always @(posedge clk)
begin
    cyc++;
    if (cyc == 30000)
    begin
        err_total++;
        report_and_stop();
    end
end
initial
begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_wait_all();
    t_stop_refused();
    t_stop_irq();
    t_stop_osc();
    t_reset_wake();
    report_and_stop();
end
endmodule
`default_nettype wire
